// file: logic/conditional_skip_unit.sv
// How it works
// [RULE_01] skip when acc equals immediate
// [RULE_02] skip when acc equals memory byte
// [RULE_03] compares set flags as subtraction, acc kept
// [RULE_04] skip when acc differs from memory byte
// [RULE_05] skip when acc differs from immediate
// [RULE_06] port bit low skips, flags untouched
// [RULE_07] port bit high skips, flags untouched
// [RULE_08] memory bit low skips, flags untouched
// [RULE_09] memory bit high skips, flags untouched
// [RULE_10] increment acc, set flags, skip on zero
// [RULE_11] decrement acc, set flags, skip on zero
// [RULE_12] increment memory, write back, skip zero
// [RULE_13] decrement memory, write back, skip zero
// [RULE_14] skipped instruction suppressed, pc moves past
`timescale 1ns/1ps
module conditional_skip_unit
  import skip_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int BW = BIT_IDX_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // instruction issue
  input wire logic instr_valid,
  input wire op_e instr_op,
  input wire logic [BW-1:0] bit_index,
  input wire logic [W-1:0] imm_data,
  // operand paths
  input wire logic [W-1:0] acc_value,
  input wire logic [W-1:0] mem_rd_data,
  input wire logic [W-1:0] io_pins,
  // sequencing
  output logic pc_advance,
  output logic skip_active,
  output logic suppress,
  // write paths
  output logic acc_wr_en,
  output logic [W-1:0] acc_wr_data,
  output logic mem_wr_en,
  output logic [W-1:0] mem_wr_data,
  // flags
  output logic flag_wr_en,
  output logic zero_flag,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic overflow_flag
);

  logic [W-1:0] io_sync;
  logic [W-1:0] alu_a;
  logic [W-1:0] alu_b;
  logic alu_sub;
  logic [W-1:0] alu_res;
  logic alu_z;
  logic alu_c;
  logic alu_hc;
  logic alu_vf;

  state_e state_reg;
  state_e state_next;
  logic pc_advance_reg;
  logic pc_advance_next;
  logic suppress_reg;
  logic suppress_next;
  logic acc_wr_en_reg;
  logic acc_wr_en_next;
  logic [W-1:0] acc_wr_data_reg;
  logic [W-1:0] acc_wr_data_next;
  logic mem_wr_en_reg;
  logic mem_wr_en_next;
  logic [W-1:0] mem_wr_data_reg;
  logic [W-1:0] mem_wr_data_next;
  logic flag_wr_en_reg;
  logic flag_wr_en_next;
  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] flags_next;

  skip_port_sync #(.W(W)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in(io_pins),
    .pin_sync(io_sync)
  );

  skip_flag_alu #(.W(W)) u_alu (
    .opa(alu_a),
    .opb(alu_b),
    .sub(alu_sub),
    .result(alu_res),
    .zero(alu_z),
    .carry(alu_c),
    .half_carry(alu_hc),
    .overflow(alu_vf)
  );

  // operand steering into the shared adder
  always_comb begin
    alu_a = acc_value;
    alu_b = ONE_VAL;
    alu_sub = 1'b1;
    case (instr_op)
      OP_CMP_EQ_IMM, OP_CMP_NE_IMM: begin
        alu_b = imm_data; // RULE_03
      end
      OP_CMP_EQ_MEM, OP_CMP_NE_MEM: begin
        alu_b = mem_rd_data; // RULE_03
      end
      OP_INC_ACC_SKIP_ZERO: begin
        alu_sub = 1'b0;
      end
      OP_INC_MEM_SKIP_ZERO: begin
        alu_a = mem_rd_data;
        alu_sub = 1'b0;
      end
      OP_DEC_MEM_SKIP_ZERO: begin
        alu_a = mem_rd_data;
      end
      default: begin
        alu_a = acc_value;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    pc_advance_next = 1'b0;
    suppress_next = 1'b0;
    acc_wr_en_next = 1'b0;
    acc_wr_data_next = acc_wr_data_reg;
    mem_wr_en_next = 1'b0;
    mem_wr_data_next = mem_wr_data_reg;
    flag_wr_en_next = 1'b0;
    flags_next = flags_reg;
    if (instr_valid) begin
      case (state_reg)
        ST_SKIP: begin
          // fetched but squashed: no writes, pc steps over it
          pc_advance_next = 1'b1; // RULE_14
          suppress_next = 1'b1; // RULE_14
          state_next = ST_RUN; // RULE_14
        end
        ST_RUN: begin
          case (instr_op)
            OP_CMP_EQ_IMM, OP_CMP_EQ_MEM: begin
              pc_advance_next = 1'b1;
              flag_wr_en_next = 1'b1; // RULE_03
              flags_next = {alu_z, alu_c, alu_hc, alu_vf}; // RULE_03
              if (alu_z) begin
                state_next = ST_SKIP; // RULE_01 RULE_02
              end
            end
            OP_CMP_NE_MEM, OP_CMP_NE_IMM: begin
              pc_advance_next = 1'b1;
              flag_wr_en_next = 1'b1; // RULE_03
              flags_next = {alu_z, alu_c, alu_hc, alu_vf}; // RULE_03
              if (!alu_z) begin
                state_next = ST_SKIP; // RULE_04 RULE_05
              end
            end
            OP_BIT_TEST_SKIP_IF_LOW_IO: begin
              pc_advance_next = 1'b1;
              if (!io_sync[bit_index]) begin
                state_next = ST_SKIP; // RULE_06
              end
            end
            OP_BIT_TEST_SKIP_IF_HIGH_IO: begin
              pc_advance_next = 1'b1;
              if (io_sync[bit_index]) begin
                state_next = ST_SKIP; // RULE_07
              end
            end
            OP_BIT_TEST_SKIP_IF_LOW_MEM: begin
              pc_advance_next = 1'b1;
              if (!mem_rd_data[bit_index]) begin
                state_next = ST_SKIP; // RULE_08
              end
            end
            OP_BIT_TEST_SKIP_IF_HIGH_MEM: begin
              pc_advance_next = 1'b1;
              if (mem_rd_data[bit_index]) begin
                state_next = ST_SKIP; // RULE_09
              end
            end
            OP_INC_ACC_SKIP_ZERO, OP_DEC_ACC_SKIP_ZERO: begin
              pc_advance_next = 1'b1;
              acc_wr_en_next = 1'b1; // RULE_10 RULE_11
              acc_wr_data_next = alu_res; // RULE_10 RULE_11
              flag_wr_en_next = 1'b1;
              flags_next = {alu_z, alu_c, alu_hc, alu_vf}; // RULE_10 RULE_11
              if (alu_z) begin
                state_next = ST_SKIP; // RULE_10 RULE_11
              end
            end
            OP_INC_MEM_SKIP_ZERO, OP_DEC_MEM_SKIP_ZERO: begin
              pc_advance_next = 1'b1;
              mem_wr_en_next = 1'b1; // RULE_12 RULE_13
              mem_wr_data_next = alu_res; // RULE_12 RULE_13
              flag_wr_en_next = 1'b1;
              flags_next = {alu_z, alu_c, alu_hc, alu_vf}; // RULE_12 RULE_13
              if (alu_z) begin
                state_next = ST_SKIP; // RULE_12 RULE_13
              end
            end
            default: begin
              state_next = ST_RUN;
            end
          endcase
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ST_RUN;
      pc_advance_reg <= 1'b0;
      suppress_reg <= 1'b0;
      acc_wr_en_reg <= 1'b0;
      acc_wr_data_reg <= ZERO_VAL;
      mem_wr_en_reg <= 1'b0;
      mem_wr_data_reg <= ZERO_VAL;
      flag_wr_en_reg <= 1'b0;
      flags_reg <= {FLAG_W{FLAG_RST}};
    end else begin
      state_reg <= state_next;
      pc_advance_reg <= pc_advance_next;
      suppress_reg <= suppress_next;
      acc_wr_en_reg <= acc_wr_en_next;
      acc_wr_data_reg <= acc_wr_data_next;
      mem_wr_en_reg <= mem_wr_en_next;
      mem_wr_data_reg <= mem_wr_data_next;
      flag_wr_en_reg <= flag_wr_en_next;
      flags_reg <= flags_next;
    end
  end

  assign pc_advance = pc_advance_reg;
  assign skip_active = (state_reg == ST_SKIP);
  assign suppress = suppress_reg;
  assign acc_wr_en = acc_wr_en_reg;
  assign acc_wr_data = acc_wr_data_reg;
  assign mem_wr_en = mem_wr_en_reg;
  assign mem_wr_data = mem_wr_data_reg;
  assign flag_wr_en = flag_wr_en_reg;
  assign zero_flag = flags_reg[ZERO_POS];
  assign carry_flag = flags_reg[CARRY_POS];
  assign half_carry_flag = flags_reg[HALF_CARRY_POS];
  assign overflow_flag = flags_reg[OVERFLOW_POS];

  logic run_issue;
  assign run_issue = instr_valid && (state_reg == ST_RUN);

  a_eq_imm_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_01
    run_issue && instr_op == OP_CMP_EQ_IMM |=> skip_active == $past(acc_value == imm_data))
    else $error("equal-immediate compare skip wrong");

  a_eq_mem_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_02
    run_issue && instr_op == OP_CMP_EQ_MEM && acc_value == mem_rd_data |=> skip_active)
    else $error("equal-memory compare did not skip");

  a_cmp_flags_only: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_03
    run_issue && instr_op inside {OP_CMP_EQ_IMM, OP_CMP_NE_IMM}
    |=> flag_wr_en && !acc_wr_en && zero_flag == $past(acc_value == imm_data)
        && carry_flag == $past(acc_value < imm_data))
    else $error("compare flags or accumulator wrong");

  a_ne_mem_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_04
    run_issue && instr_op == OP_CMP_NE_MEM |=> skip_active == $past(acc_value != mem_rd_data))
    else $error("not-equal memory compare skip wrong");

  a_ne_imm_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_05
    run_issue && instr_op == OP_CMP_NE_IMM && acc_value == imm_data |=> !skip_active)
    else $error("not-equal immediate skipped on match");

  a_io_low_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_06
    run_issue && instr_op == OP_BIT_TEST_SKIP_IF_LOW_IO
    |=> skip_active == !$past(io_sync[bit_index]) && !flag_wr_en)
    else $error("port low test wrong");

  a_io_high_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_07
    run_issue && instr_op == OP_BIT_TEST_SKIP_IF_HIGH_IO
    |=> skip_active == $past(io_sync[bit_index]) && $stable(flags_reg))
    else $error("port high test wrong");

  a_mem_low_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_08
    run_issue && instr_op == OP_BIT_TEST_SKIP_IF_LOW_MEM
    |=> skip_active == !$past(mem_rd_data[bit_index]) && !flag_wr_en)
    else $error("memory low test wrong");

  a_mem_high_skip: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_09
    run_issue && instr_op == OP_BIT_TEST_SKIP_IF_HIGH_MEM
    |=> skip_active == $past(mem_rd_data[bit_index]) && $stable(flags_reg))
    else $error("memory high test wrong");

  a_inc_acc_value: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_10
    run_issue && instr_op == OP_INC_ACC_SKIP_ZERO
    |=> acc_wr_en && acc_wr_data == W'($past(acc_value) + ONE_VAL)
        && skip_active == (acc_wr_data == ZERO_VAL))
    else $error("accumulator increment wrong");

  a_dec_acc_value: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_11
    run_issue && instr_op == OP_DEC_ACC_SKIP_ZERO && acc_value == ONE_VAL
    |=> acc_wr_en && acc_wr_data == ZERO_VAL && skip_active && zero_flag)
    else $error("accumulator decrement wrong");

  a_inc_mem_value: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_12
    run_issue && instr_op == OP_INC_MEM_SKIP_ZERO
    |=> mem_wr_en && !acc_wr_en && mem_wr_data == W'($past(mem_rd_data) + ONE_VAL))
    else $error("memory increment wrong");

  a_dec_mem_value: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_13
    run_issue && instr_op == OP_DEC_MEM_SKIP_ZERO
    |=> mem_wr_en && mem_wr_data == W'($past(mem_rd_data) - ONE_VAL)
        && skip_active == zero_flag)
    else $error("memory decrement wrong");

  a_skip_squash: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE_14
    instr_valid && skip_active
    |=> suppress && pc_advance && !acc_wr_en && !mem_wr_en && !flag_wr_en
        && !skip_active && $stable(flags_reg))
    else $error("skipped instruction not suppressed");

endmodule : conditional_skip_unit

// file: logic/skip_pkg.sv
package skip_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_IDX_W = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [DATA_W-1:0] ONE_VAL = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_VAL = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam int FLAG_W = 4;
  localparam int ZERO_POS = 3;
  localparam int CARRY_POS = 2;
  localparam int HALF_CARRY_POS = 1;
  localparam int OVERFLOW_POS = 0;

  // instruction classes handed over by the core decoder
  typedef enum logic [3:0] {
    OP_OTHER,
    OP_CMP_EQ_IMM,
    OP_CMP_EQ_MEM,
    OP_CMP_NE_MEM,
    OP_CMP_NE_IMM,
    OP_BIT_TEST_SKIP_IF_LOW_IO,
    OP_BIT_TEST_SKIP_IF_HIGH_IO,
    OP_BIT_TEST_SKIP_IF_LOW_MEM,
    OP_BIT_TEST_SKIP_IF_HIGH_MEM,
    OP_INC_ACC_SKIP_ZERO,
    OP_DEC_ACC_SKIP_ZERO,
    OP_INC_MEM_SKIP_ZERO,
    OP_DEC_MEM_SKIP_ZERO
  } op_e;

  typedef enum logic {
    ST_RUN,
    ST_SKIP
  } state_e;

endpackage : skip_pkg

// file: logic/skip_flag_alu.sv
`timescale 1ns/1ps
module skip_flag_alu
  import skip_pkg::*;
#(
  parameter int W = DATA_W
) (
  // operands
  input wire logic [W-1:0] opa,
  input wire logic [W-1:0] opb,
  input wire logic sub,
  // result and flags
  output logic [W-1:0] result,
  output logic zero,
  output logic carry,
  output logic half_carry,
  output logic overflow
);

  localparam int HALF = W / 2;

  logic [W:0] full;
  logic [HALF:0] low;

  always_comb begin
    if (sub) begin
      full = {1'b0, opa} - {1'b0, opb};
      low = {1'b0, opa[HALF-1:0]} - {1'b0, opb[HALF-1:0]};
      overflow = (opa[W-1] ^ opb[W-1]) & (opa[W-1] ^ full[W-1]);
    end else begin
      full = {1'b0, opa} + {1'b0, opb};
      low = {1'b0, opa[HALF-1:0]} + {1'b0, opb[HALF-1:0]};
      overflow = ~(opa[W-1] ^ opb[W-1]) & (opa[W-1] ^ full[W-1]);
    end
    result = full[W-1:0];
    // carry doubles as borrow on subtraction
    carry = full[W];
    half_carry = low[HALF];
    zero = (full[W-1:0] == '0);
  end

endmodule : skip_flag_alu

// file: logic/skip_port_sync.sv
`timescale 1ns/1ps
module skip_port_sync
  import skip_pkg::*;
#(
  parameter int W = DATA_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_sync = sync_reg;

endmodule : skip_port_sync

// file: dv/conditional_skip_unit_tb_top.sv
`timescale 1ns/1ps
module conditional_skip_unit_tb_top;
  import skip_pkg::*;

  typedef struct packed {
    logic pc;
    logic skip;
    logic aw;
    logic [7:0] ad;
    logic mw;
    logic [7:0] md;
    logic fw;
    logic [3:0] fl;
  } exp_s;

  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  op_e instr_op = OP_OTHER;
  logic [2:0] bit_index = 3'h0;
  logic [7:0] imm_data = 8'h00;
  logic [7:0] acc_value = 8'h00;
  logic [7:0] mem_rd_data = 8'h00;
  logic [7:0] io_pins = 8'h00;
  logic pc_advance, skip_active, suppress, acc_wr_en, mem_wr_en, flag_wr_en;
  logic [7:0] acc_wr_data, mem_wr_data;
  logic zero_flag, carry_flag, half_carry_flag, overflow_flag;
  logic [3:0] flags_q = 4'h0;
  logic [7:0] vals [6] = '{8'hff, 8'h7f, 8'h0f, 8'h00, 8'h01, 8'h80};
  int err_count = 0;
  int n_compared = 0;
  int seed_dummy;

  always #25 ref_clk = ~ref_clk;

  conditional_skip_unit dut (
    .ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .bit_index(bit_index), .imm_data(imm_data), .acc_value(acc_value),
    .mem_rd_data(mem_rd_data), .io_pins(io_pins), .pc_advance(pc_advance),
    .skip_active(skip_active), .suppress(suppress), .acc_wr_en(acc_wr_en),
    .acc_wr_data(acc_wr_data), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .flag_wr_en(flag_wr_en), .zero_flag(zero_flag), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .overflow_flag(overflow_flag)
  );

  // flags of a - b: zero, borrow, borrow out of bit 3, signed overflow
  function automatic logic [3:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {r == 8'h00, a < b, a[3:0] < b[3:0], (a[7] ^ b[7]) & (a[7] ^ r[7])};
  endfunction : sub_flags

  function automatic exp_s model(input op_e op, input logic [2:0] bi, input logic [7:0] im,
                                 input logic [7:0] av, input logic [7:0] me,
                                 input logic [7:0] io);
    exp_s e;
    logic [7:0] src;
    e = '0;
    e.pc = 1'b1;
    src = (op inside {OP_INC_ACC_SKIP_ZERO, OP_DEC_ACC_SKIP_ZERO}) ? av : me;
    case (op)
      OP_CMP_EQ_IMM, OP_CMP_NE_IMM: begin
        e.fw = 1'b1;
        e.fl = sub_flags(av, im);
        e.skip = (av == im) ^ (op == OP_CMP_NE_IMM);
      end
      OP_CMP_EQ_MEM, OP_CMP_NE_MEM: begin
        e.fw = 1'b1;
        e.fl = sub_flags(av, me);
        e.skip = (av == me) ^ (op == OP_CMP_NE_MEM);
      end
      OP_BIT_TEST_SKIP_IF_LOW_IO: e.skip = !io[bi];
      OP_BIT_TEST_SKIP_IF_HIGH_IO: e.skip = io[bi];
      OP_BIT_TEST_SKIP_IF_LOW_MEM: e.skip = !me[bi];
      OP_BIT_TEST_SKIP_IF_HIGH_MEM: e.skip = me[bi];
      OP_INC_ACC_SKIP_ZERO, OP_INC_MEM_SKIP_ZERO: begin
        e.fw = 1'b1;
        e.ad = src + 8'h01;
        e.fl = {e.ad == 8'h00, src == 8'hff, src[3:0] == 4'hf, src == 8'h7f};
      end
      OP_DEC_ACC_SKIP_ZERO, OP_DEC_MEM_SKIP_ZERO: begin
        e.fw = 1'b1;
        e.ad = src - 8'h01;
        e.fl = {e.ad == 8'h00, src == 8'h00, src[3:0] == 4'h0, src == 8'h80};
      end
      default: e.pc = 1'b0;
    endcase
    if (op inside {OP_INC_ACC_SKIP_ZERO, OP_DEC_ACC_SKIP_ZERO}) begin
      e.aw = 1'b1;
    end
    if (op inside {OP_INC_MEM_SKIP_ZERO, OP_DEC_MEM_SKIP_ZERO}) begin
      e.mw = 1'b1;
      e.md = e.ad;
    end
    if (e.aw | e.mw) begin
      e.skip = (e.ad == 8'h00);
    end
    return e;
  endfunction : model

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_flags();
    cmp_byte({4'h0, zero_flag, carry_flag, half_carry_flag, overflow_flag},
             {4'h0, flags_q}, "flags");
  endtask : cmp_flags

  // squashed follower, any class, random operands
  task automatic squash();
    instr_op = op_e'($urandom_range(0, 12));
    bit_index = 3'($urandom);
    imm_data = 8'($urandom);
    acc_value = 8'($urandom);
    mem_rd_data = 8'($urandom);
    @(negedge ref_clk);
    cmp_bit(suppress, 1'b1, "suppress");
    cmp_bit(pc_advance, 1'b1, "pc_advance after squash");
    cmp_bit(skip_active, 1'b0, "skip cleared");
    cmp_bit(acc_wr_en | mem_wr_en | flag_wr_en, 1'b0, "writes on squash");
    cmp_flags();
  endtask : squash

  // called at a falling edge; leaves instr_valid high for back-to-back issue
  task automatic issue(input op_e op, input logic [2:0] bi, input logic [7:0] im,
                       input logic [7:0] av, input logic [7:0] me);
    exp_s e;
    e = model(op, bi, im, av, me, io_pins);
    instr_valid = 1'b1;
    instr_op = op;
    bit_index = bi;
    imm_data = im;
    acc_value = av;
    mem_rd_data = me;
    @(negedge ref_clk);
    cmp_bit(pc_advance, e.pc, "pc_advance");
    cmp_bit(suppress, 1'b0, "suppress");
    cmp_bit(skip_active, e.skip, "skip");
    cmp_bit(acc_wr_en, e.aw, "acc_wr_en");
    if (e.aw) cmp_byte(acc_wr_data, e.ad, "acc_wr_data");
    cmp_bit(mem_wr_en, e.mw, "mem_wr_en");
    if (e.mw) cmp_byte(mem_wr_data, e.md, "mem_wr_data");
    cmp_bit(flag_wr_en, e.fw, "flag_wr_en");
    if (e.fw) flags_q = e.fl;
    cmp_flags();
    if (e.skip) squash();
  endtask : issue

  task automatic set_io(input logic [7:0] v);
    instr_valid = 1'b0;
    io_pins = v;
    repeat (3) @(negedge ref_clk);
  endtask : set_io

  task automatic end_test(input string name);
    instr_valid = 1'b0;
    @(negedge ref_clk);
    $display("test %s done, mismatches so far %0d", name, err_count);
  endtask : end_test

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(20000 * 50);
    err_count++;
    stop_test();
  end

  initial begin
    seed_dummy = $urandom(32'h2412);
    repeat (20) @(negedge ref_clk);
    cmp_bit(pc_advance | skip_active | suppress | flag_wr_en, 1'b0, "reset outputs");
    resetn = 1'b1;
    issue(OP_CMP_EQ_IMM, 3'h0, 8'h55, 8'h55, 8'h00);
    issue(OP_CMP_EQ_IMM, 3'h0, 8'h55, 8'h54, 8'h00);
    issue(OP_CMP_EQ_MEM, 3'h0, 8'h00, 8'h80, 8'h80);
    issue(OP_CMP_EQ_MEM, 3'h0, 8'h00, 8'h7f, 8'h80);
    issue(OP_CMP_NE_MEM, 3'h0, 8'h00, 8'h10, 8'h01);
    issue(OP_CMP_NE_MEM, 3'h0, 8'h00, 8'h33, 8'h33);
    issue(OP_CMP_NE_IMM, 3'h0, 8'h55, 8'h55, 8'h00);
    issue(OP_CMP_NE_IMM, 3'h0, 8'h01, 8'h00, 8'h00);
    issue(OP_OTHER, 3'h0, 8'h00, 8'h00, 8'h00);
    end_test("compare");
    for (int op = 9; op <= 12; op++) begin
      foreach (vals[i]) issue(op_e'(op), 3'h0, 8'h00, vals[i], vals[i]);
    end
    end_test("count");
    for (int i = 0; i < 8; i++) begin
      set_io(8'h01 << i);
      issue(OP_CMP_EQ_IMM, 3'h0, 8'h01, 8'h00, 8'h00);
      issue(OP_BIT_TEST_SKIP_IF_LOW_IO, 3'(i), 8'h00, 8'h00, 8'h00);
      issue(OP_BIT_TEST_SKIP_IF_HIGH_IO, 3'(i), 8'h00, 8'h00, 8'h00);
      issue(OP_BIT_TEST_SKIP_IF_LOW_IO, 3'(i + 1), 8'h00, 8'h00, 8'h00);
      issue(OP_BIT_TEST_SKIP_IF_HIGH_IO, 3'(i + 1), 8'h00, 8'h00, 8'h00);
      issue(OP_BIT_TEST_SKIP_IF_LOW_MEM, 3'(i), 8'h00, 8'h00, 8'h01 << i);
      issue(OP_BIT_TEST_SKIP_IF_HIGH_MEM, 3'(i), 8'h00, 8'h00, 8'h01 << i);
      issue(OP_BIT_TEST_SKIP_IF_LOW_MEM, 3'(i), 8'h00, 8'h00, ~(8'h01 << i));
      issue(OP_BIT_TEST_SKIP_IF_HIGH_MEM, 3'(i), 8'h00, 8'h00, ~(8'h01 << i));
    end
    end_test("bit");
    repeat (400) begin
      if ($urandom_range(0, 39) == 0) set_io(8'($urandom));
      issue(op_e'($urandom_range(0, 12)), 3'($urandom), 8'($urandom), 8'($urandom),
            8'($urandom));
    end
    end_test("random");
    instr_valid = 1'b1;
    instr_op = OP_CMP_EQ_IMM;
    imm_data = 8'h5a;
    acc_value = 8'h5a;
    @(negedge ref_clk);
    cmp_bit(skip_active, 1'b1, "skip before reset");
    resetn = 1'b0;
    instr_valid = 1'b0;
    @(negedge ref_clk);
    cmp_bit(skip_active, 1'b0, "skip after reset");
    flags_q = 4'h0;
    cmp_flags();
    resetn = 1'b1;
    issue(OP_INC_ACC_SKIP_ZERO, 3'h0, 8'h00, 8'h05, 8'h00);
    end_test("reset");
    stop_test();
  end

endmodule : conditional_skip_unit_tb_top
